// ### rtl/csf_flags.sv
// Functional notes
// [RULE1] each accumulator clip flag is sticky: set on clipping, held until software clears it
// [RULE2] either_acc_overflow reads one whenever either accumulator overflow flag is set
// [RULE3] either_acc_clip reads one whenever either sticky clip flag is set
// [RULE4] nibble_carry marks carry or borrow at bit 4 (byte) or bit 8 (word)
// [RULE5] priority level bits ignore data writes while nesting_disable is one
// [RULE6] clip flags change by writing them directly or by clearing either_acc_clip
// [RULE7] software should not use read-modify-write bit operations on clip flags
// [RULE8] reset clears every status flag before the first instruction runs
//
// The address map and the AHB-Lite slave port are this design's own decisions.
module csf_flags #(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // accumulator datapath
   input wire logic acc_upd_i,
   input wire logic acc_a_ovf_i,
   input wire logic acc_b_ovf_i,
   input wire logic acc_a_sat_i,
   input wire logic acc_b_sat_i,
   // alu for the nibble carry
   input wire logic alu_valid_i,
   input wire logic [DATA_W-1:0] alu_a_i,
   input wire logic [DATA_W-1:0] alu_b_i,
   input wire logic alu_sub_i,
   input wire logic alu_byte_i,
   // outputs
   output logic [csf_pkg::FLAGS_W-1:0] cpu_flags_register_o,
   output logic [csf_pkg::PRIO_W-1:0] cpu_priority_level_o,
   output logic nesting_disable_o,
   output logic irq_o
);

   generate
      if (DATA_W != csf_pkg::FLAGS_W) begin : g_chk
         $error("csf_flags: DATA_W must equal the status register width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic addr_is(input logic [csf_pkg::ADDR_W-1:0] a,
                                    input logic [csf_pkg::ADDR_W-1:0] ref_a);
      addr_is = (a == ref_a);
   endfunction : addr_is

   // hardware set wins over a software clear in the same cycle
   function automatic logic sticky_next(input logic cur, input logic sw_we,
                                        input logic sw_val, input logic hw_set);
      logic keep;
      begin
         keep = sw_we ? sw_val : cur;
         sticky_next = keep | hw_set;
      end
   endfunction : sticky_next

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic acc_a_ovf_reg;
   logic acc_a_ovf_next;
   logic acc_b_ovf_reg;
   logic acc_b_ovf_next;
   logic acc_a_clip_sticky_reg;
   logic acc_a_clip_sticky_next;
   logic acc_b_clip_sticky_reg;
   logic acc_b_clip_sticky_next;
   logic nibble_carry_reg;
   logic nibble_carry_next;
   logic [csf_pkg::PRIO_W-1:0] prio_reg;
   logic [csf_pkg::PRIO_W-1:0] prio_next;
   logic [csf_pkg::LOW_FLAGS_W-1:0] low_flags_reg;
   logic [csf_pkg::LOW_FLAGS_W-1:0] low_flags_next;
   logic nesting_disable_reg;
   logic nesting_disable_next;
   logic [csf_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [csf_pkg::IRQ_W-1:0] irq_stat_next;
   logic [csf_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [csf_pkg::IRQ_W-1:0] irq_mask_next;

   // bus pipeline
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [csf_pkg::ADDR_W-1:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic hreadyout_reg;
   logic hreadyout_next;
   logic hresp_reg;
   logic irq_reg;
   logic [csf_pkg::FLAGS_W-1:0] flags_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire logic addr_phase;
   wire logic wr_flags;
   wire logic wr_ctrl;
   wire logic wr_mask;
   wire logic rd_flags;
   wire logic rd_ctrl;
   wire logic rd_stat;
   wire logic rd_mask;
   wire logic rd_done;

   // a read takes one wait state so hrdata comes from a flop and sees earlier writes
   assign addr_phase = hsel_i & hready_i & (htrans_i == csf_pkg::HTRANS_NONSEQ);
   assign wr_flags = wr_pend_reg & addr_is(addr_reg, csf_pkg::ADDR_FLAGS);
   assign wr_ctrl = wr_pend_reg & addr_is(addr_reg, csf_pkg::ADDR_CTRL);
   assign wr_mask = wr_pend_reg & addr_is(addr_reg, csf_pkg::ADDR_IRQ_MASK);
   assign rd_done = rd_pend_reg & ~hreadyout_reg;
   assign rd_flags = addr_is(addr_reg, csf_pkg::ADDR_FLAGS);
   assign rd_ctrl = addr_is(addr_reg, csf_pkg::ADDR_CTRL);
   assign rd_stat = rd_done & addr_is(addr_reg, csf_pkg::ADDR_IRQ_STAT);
   assign rd_mask = addr_is(addr_reg, csf_pkg::ADDR_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // flag updates

   wire logic hw_carry;
   wire logic sat_a_evt;
   wire logic sat_b_evt;
   wire logic ovf_evt;
   wire logic clip_group_clear;
   wire logic clip_wr_a;
   wire logic clip_wr_b;
   wire logic either_ovf;
   wire logic either_clip;
   wire logic [csf_pkg::FLAGS_W-1:0] flags_image;

   csf_nibble_carry #(
      .DATA_W(DATA_W)
   ) u_carry (
      .a_i(alu_a_i),
      .b_i(alu_b_i),
      .sub_i(alu_sub_i),
      .byte_i(alu_byte_i),
      .carry_o(hw_carry)
   );

   assign sat_a_evt = acc_upd_i & acc_a_sat_i;
   assign sat_b_evt = acc_upd_i & acc_b_sat_i;
   assign ovf_evt = acc_upd_i & (acc_a_ovf_i | acc_b_ovf_i);

   // writing zero to either_acc_clip drops both clip flags
   assign clip_group_clear = wr_flags & ~hwdata_i[csf_pkg::BIT_EITHER_CLIP]; // see [RULE6]
   assign clip_wr_a = clip_group_clear ? 1'b0 : hwdata_i[csf_pkg::BIT_ACC_A_CLIP];
   assign clip_wr_b = clip_group_clear ? 1'b0 : hwdata_i[csf_pkg::BIT_ACC_B_CLIP];

   // a single word write cannot split the clip pair, which is why bit operations race
   assign acc_a_clip_sticky_next =
      sticky_next(acc_a_clip_sticky_reg, wr_flags, clip_wr_a, sat_a_evt); // see [RULE1] [RULE6]
   assign acc_b_clip_sticky_next =
      sticky_next(acc_b_clip_sticky_reg, wr_flags, clip_wr_b, sat_b_evt); // see [RULE1] [RULE6]

   // overflow flags track the latest accumulator result; datapath beats a write
   assign acc_a_ovf_next = acc_upd_i ? acc_a_ovf_i :
                           wr_flags ? hwdata_i[csf_pkg::BIT_ACC_A_OVF] : acc_a_ovf_reg;
   assign acc_b_ovf_next = acc_upd_i ? acc_b_ovf_i :
                           wr_flags ? hwdata_i[csf_pkg::BIT_ACC_B_OVF] : acc_b_ovf_reg;

   assign nibble_carry_next = alu_valid_i ? hw_carry : // see [RULE4]
                              wr_flags ? hwdata_i[csf_pkg::BIT_NIBBLE_CARRY] : nibble_carry_reg;

   assign prio_next = (wr_flags & ~nesting_disable_reg) ? // see [RULE5]
                      hwdata_i[csf_pkg::PRIO_HI:csf_pkg::PRIO_LO] : prio_reg;
   assign low_flags_next = wr_flags ?
                           hwdata_i[csf_pkg::LOW_FLAGS_HI:csf_pkg::LOW_FLAGS_LO] : low_flags_reg;
   assign nesting_disable_next = wr_ctrl ?
                                 hwdata_i[csf_pkg::BIT_NESTING_DISABLE] : nesting_disable_reg;

   // summary bits are derived, so they can never disagree with their sources
   assign either_ovf = acc_a_ovf_reg | acc_b_ovf_reg; // see [RULE2]
   assign either_clip = acc_a_clip_sticky_reg | acc_b_clip_sticky_reg; // see [RULE3]

   assign flags_image = {acc_a_ovf_reg,
                         acc_b_ovf_reg,
                         acc_a_clip_sticky_reg,
                         acc_b_clip_sticky_reg,
                         either_ovf,
                         either_clip,
                         1'b0,
                         nibble_carry_reg,
                         prio_reg,
                         1'b0,
                         low_flags_reg};

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky events, cleared by reading, new events win

   wire logic [csf_pkg::IRQ_W-1:0] irq_evt;
   wire logic [csf_pkg::IRQ_W-1:0] irq_kept;

   assign irq_evt = {ovf_evt, sat_b_evt, sat_a_evt};
   assign irq_kept = rd_stat ? csf_pkg::IRQ_RESET : irq_stat_reg;
   assign irq_stat_next = irq_kept | irq_evt;
   assign irq_mask_next = wr_mask ? hwdata_i[csf_pkg::IRQ_W-1:0] : irq_mask_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read data and wait state

   wire logic [31:0] rd_word;

   assign rd_word = rd_flags ? {{(32-csf_pkg::FLAGS_W){1'b0}}, flags_image} :
                    rd_ctrl ? {31'h0000_0000, nesting_disable_reg} :
                    addr_is(addr_reg, csf_pkg::ADDR_IRQ_STAT) ?
                       {{(32-csf_pkg::IRQ_W){1'b0}}, irq_stat_reg} :
                    rd_mask ? {{(32-csf_pkg::IRQ_W){1'b0}}, irq_mask_reg} :
                    32'h0000_0000;

   assign hrdata_next = rd_done ? rd_word : hrdata_reg;
   assign hreadyout_next = (addr_phase & ~hwrite_i) ? 1'b0 : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= csf_pkg::ADDR_FLAGS;
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
         hresp_reg <= csf_pkg::HRESP_OKAY;
      end else if (ce_i) begin
         wr_pend_reg <= addr_phase & hwrite_i;
         rd_pend_reg <= addr_phase & ~hwrite_i;
         if (addr_phase) begin
            addr_reg <= haddr_i[csf_pkg::ADDR_W-1:0];
         end
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= hreadyout_next;
         hresp_reg <= csf_pkg::HRESP_OKAY;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin // see [RULE8]
         acc_a_ovf_reg <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_ACC_A_OVF];
         acc_b_ovf_reg <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_ACC_B_OVF];
         acc_a_clip_sticky_reg <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_ACC_A_CLIP];
         acc_b_clip_sticky_reg <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_ACC_B_CLIP];
         nibble_carry_reg <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_NIBBLE_CARRY];
         prio_reg <= csf_pkg::FLAGS_RESET[csf_pkg::PRIO_HI:csf_pkg::PRIO_LO];
         low_flags_reg <= csf_pkg::FLAGS_RESET[csf_pkg::LOW_FLAGS_HI:csf_pkg::LOW_FLAGS_LO];
         nesting_disable_reg <= 1'b0;
      end else if (ce_i) begin
         acc_a_ovf_reg <= acc_a_ovf_next;
         acc_b_ovf_reg <= acc_b_ovf_next;
         acc_a_clip_sticky_reg <= acc_a_clip_sticky_next;
         acc_b_clip_sticky_reg <= acc_b_clip_sticky_next;
         nibble_carry_reg <= nibble_carry_next;
         prio_reg <= prio_next;
         low_flags_reg <= low_flags_next;
         nesting_disable_reg <= nesting_disable_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         irq_stat_reg <= csf_pkg::IRQ_RESET;
         irq_mask_reg <= csf_pkg::IRQ_RESET;
         irq_reg <= 1'b0;
         flags_out_reg <= csf_pkg::FLAGS_RESET;
      end else if (ce_i) begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         // one cycle behind the status bit, traded for a flop-driven pin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
         flags_out_reg <= flags_image;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign hrdata_o = hrdata_reg;
   assign hreadyout_o = hreadyout_reg;
   assign hresp_o = hresp_reg;
   assign irq_o = irq_reg;
   assign cpu_flags_register_o = flags_out_reg;
   assign cpu_priority_level_o = prio_reg;
   assign nesting_disable_o = nesting_disable_reg;

endmodule : csf_flags

// ### rtl/csf_pkg.sv
package csf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus map, byte addresses of the 32-bit words
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam int ADDR_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // cpu_flags_register layout
   localparam int FLAGS_W = 16;
   localparam int BIT_ACC_A_OVF = 15;
   localparam int BIT_ACC_B_OVF = 14;
   localparam int BIT_ACC_A_CLIP = 13;
   localparam int BIT_ACC_B_CLIP = 12;
   localparam int BIT_EITHER_OVF = 11;
   localparam int BIT_EITHER_CLIP = 10;
   localparam int BIT_LOOP_ACTIVE = 9;
   localparam int BIT_NIBBLE_CARRY = 8;
   localparam int PRIO_HI = 7;
   localparam int PRIO_LO = 5;
   localparam int BIT_REPEAT_ACTIVE = 4;
   localparam int LOW_FLAGS_HI = 3;
   localparam int LOW_FLAGS_LO = 0;
   localparam int PRIO_W = PRIO_HI - PRIO_LO + 1;
   localparam int LOW_FLAGS_W = LOW_FLAGS_HI - LOW_FLAGS_LO + 1;
   localparam logic [FLAGS_W-1:0] FLAGS_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // control register
   localparam int BIT_NESTING_DISABLE = 0;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status / mask layout
   localparam int IRQ_W = 3;
   localparam int IRQ_ACC_A_CLIP = 0;
   localparam int IRQ_ACC_B_CLIP = 1;
   localparam int IRQ_OVF = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // nibble carry tap points
   localparam int BYTE_CARRY_BIT = 4;
   localparam int WORD_CARRY_BIT = 8;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

endpackage : csf_pkg

// ### rtl/csf_nibble_carry.sv
module csf_nibble_carry #(
   parameter int DATA_W = 16
) (
   input wire logic [DATA_W-1:0] a_i,
   input wire logic [DATA_W-1:0] b_i,
   input wire logic sub_i,
   input wire logic byte_i,
   output logic carry_o
);

   generate
      if (DATA_W < csf_pkg::WORD_CARRY_BIT) begin : g_chk
         $error("csf_nibble_carry: operand width too small");
      end
   endgenerate

   // carry out of the low n bits of a + (b or ~b) + sub
   function automatic logic lane_carry(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                       input logic sub, input int n);
      logic [DATA_W:0] sum;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] bb;
      begin
         mask = (DATA_W)'((1 << n) - 1);
         bb = sub ? ~b : b;
         sum = {1'b0, a & mask} + {1'b0, bb & mask} + {{DATA_W{1'b0}}, sub};
         lane_carry = sum[n];
      end
   endfunction : lane_carry

   wire logic byte_c;
   wire logic word_c;
   wire logic raw_c;

   assign byte_c = lane_carry(a_i, b_i, sub_i, csf_pkg::BYTE_CARRY_BIT);
   assign word_c = lane_carry(a_i, b_i, sub_i, csf_pkg::WORD_CARRY_BIT);
   assign raw_c = byte_i ? byte_c : word_c;
   // subtract: a missing carry is a borrow into the tap bit
   assign carry_o = sub_i ? ~raw_c : raw_c; // see [RULE4]

endmodule : csf_nibble_carry

// ### verif/csf_flags_assertions.sv
module csf_flags_assertions #(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic acc_upd_i,
   input wire logic acc_a_sat_i,
   input wire logic alu_valid_i,
   input wire logic [DATA_W-1:0] alu_a_i,
   input wire logic [DATA_W-1:0] alu_b_i,
   input wire logic alu_sub_i,
   input wire logic alu_byte_i,
   input wire logic [csf_pkg::FLAGS_W-1:0] cpu_flags_register_o,
   input wire logic [csf_pkg::PRIO_W-1:0] cpu_priority_level_o,
   input wire logic nesting_disable_o,
   input wire logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // low operand slices, widened by one bit to catch the carry
   wire logic [8:0] lo_a = alu_byte_i ? {5'h0, alu_a_i[3:0]} : {1'b0, alu_a_i[7:0]};
   wire logic [8:0] lo_b = alu_byte_i ? {5'h0, alu_b_i[3:0]} : {1'b0, alu_b_i[7:0]};
   wire logic [8:0] lo_sum = lo_a + lo_b;
   wire logic nc_exp = alu_sub_i ? (lo_a < lo_b) : (alu_byte_i ? lo_sum[4] : lo_sum[8]);
   wire logic taken = hsel_i && hready_i && htrans_i == csf_pkg::HTRANS_NONSEQ;
   wire logic flags_wr = taken && hwrite_i && haddr_i[7:0] == csf_pkg::ADDR_FLAGS;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   ////////////////////////////////////////////////////////////////////////////
   either_ovf_a: assert property (
      cpu_flags_register_o[11] == (cpu_flags_register_o[15] | cpu_flags_register_o[14]))
      else $error("either overflow bit wrong");
   either_clip_a: assert property (
      cpu_flags_register_o[10] == (cpu_flags_register_o[13] | cpu_flags_register_o[12]))
      else $error("either clip bit wrong");
   clip_set_a: assert property (
      acc_upd_i && acc_a_sat_i && ce_i ##1 ce_i |-> ##1 cpu_flags_register_o[13])
      else $error("clip flag not set");
   clip_clear_a: assert property (
      $fell(cpu_flags_register_o[13]) |-> $past(flags_wr, 3))
      else $error("clip flag dropped without a write");
   nibble_carry_a: assert property (
      alu_valid_i && ce_i ##1 ce_i |-> ##1 cpu_flags_register_o[8] == $past(nc_exp, 2))
      else $error("nibble carry wrong");
   prio_locked_a: assert property (
      nesting_disable_o [*5] |-> $stable(cpu_priority_level_o))
      else $error("priority changed while locked");
   reset_clear_a: assert property (
      $rose(nrst_i) && $past(ce_i) |-> cpu_flags_register_o == '0 && !irq_o)
      else $error("flags not cleared by reset");
   read_wait_a: assert property (
      taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
endmodule : csf_flags_assertions

bind csf_flags csf_flags_assertions #(.DATA_W(DATA_W)) i_chk (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
   .acc_upd_i(acc_upd_i), .acc_a_sat_i(acc_a_sat_i), .alu_valid_i(alu_valid_i),
   .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .alu_sub_i(alu_sub_i), .alu_byte_i(alu_byte_i),
   .cpu_flags_register_o(cpu_flags_register_o), .cpu_priority_level_o(cpu_priority_level_o),
   .nesting_disable_o(nesting_disable_o), .irq_o(irq_o));

// ### verif/csf_flags_tb.sv
module csf_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0, nrst_i = 0, ce_i = 1, hsel_i = 0, hwrite_i = 0;
   logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd, d, e;
   logic [1:0] htrans_i = '0;
   logic [2:0] hsize_i = 3'h2, cpu_priority_level_o, mst, mmsk;
   logic hreadyout_o, hresp_o, irq_o, nesting_disable_o, nd;
   logic acc_upd_i = 0, acc_a_ovf_i = 0, acc_b_ovf_i = 0, acc_a_sat_i = 0, acc_b_sat_i = 0;
   logic alu_valid_i = 0, alu_sub_i = 0, alu_byte_i = 0;
   logic [15:0] alu_a_i = '0, alu_b_i = '0, cpu_flags_register_o, mf;
   wire logic hready_i = hreadyout_o;
   int fails = 0, check_count = 0, seed = 32'h3d80;

   always #2.5 ref_clk_i = ~ref_clk_i;

   csf_flags #(.DATA_W(16)) i_dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .acc_upd_i(acc_upd_i), .acc_a_ovf_i(acc_a_ovf_i), .acc_b_ovf_i(acc_b_ovf_i),
      .acc_a_sat_i(acc_a_sat_i), .acc_b_sat_i(acc_b_sat_i), .alu_valid_i(alu_valid_i),
      .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .alu_sub_i(alu_sub_i), .alu_byte_i(alu_byte_i),
      .cpu_flags_register_o(cpu_flags_register_o), .cpu_priority_level_o(cpu_priority_level_o),
      .nesting_disable_o(nesting_disable_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // no cycle limit of its own: a dead bus is ended by the watchdog
   task wait_rdy;
      do begin
         @(posedge ref_clk_i);
      end while (hreadyout_o !== 1'b1);
   endtask : wait_rdy

   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      htrans_i <= csf_pkg::HTRANS_NONSEQ;
      wait_rdy();
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_rdy();
      rd = hrdata_o;
      check("hresp", {31'h0, hresp_o}, 32'h0);
   endtask : xfer

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(nm, rd, exp);
   endtask : rd_chk

   function automatic logic [31:0] img();
      return {16'h0, mf[15:12], mf[15] | mf[14], mf[13] | mf[12], 1'b0, mf[8], mf[7:5], 1'b0,
         mf[3:0]};
   endfunction : img

   function automatic logic nib(input logic [15:0] a, input logic [15:0] b, input logic s,
      input logic by);
      logic [8:0] x, y, z;
      x = by ? {5'h0, a[3:0]} : {1'b0, a[7:0]};
      y = by ? {5'h0, b[3:0]} : {1'b0, b[7:0]};
      z = x + y;
      if (s) return x < y;
      return by ? z[4] : z[8];
   endfunction : nib

   task wr_flags(input logic [15:0] v);
      mf[15:14] = v[15:14];
      mf[13:12] = v[10] ? v[13:12] : 2'h0;
      mf[8] = v[8];
      if (!nd) mf[7:5] = v[7:5];
      mf[3:0] = v[3:0];
      // whole-word write only, never a bit operation on the clip pair
      xfer(csf_pkg::ADDR_FLAGS, 1'b1, {16'h0, v});
   endtask : wr_flags

   // reset, then every register and one unmapped word must read zero
   task reset_chk;
      nrst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      mf = '0;
      mst = '0;
      mmsk = '0;
      nd = 1'b0;
      for (int a = 0; a < 20; a += 4) rd_chk("reset read", 8'(a), 32'h0);
      check("reset irq", {31'h0, irq_o}, 32'h0);
   endtask : reset_chk

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_chk();
      xfer(8'h10, 1'b1, 32'hffff_ffff);
      rd_chk("unmapped", 8'h10, 32'h0);
      // clock enable low: a saturating result must leave no trace
      ce_i <= 1'b0;
      acc_upd_i <= 1'b1;
      acc_a_sat_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      acc_upd_i <= 1'b0;
      acc_a_sat_i <= 1'b0;
      ce_i <= 1'b1;
      rd_chk("frozen flags", csf_pkg::ADDR_FLAGS, 32'h0);
      rd_chk("frozen stat", csf_pkg::ADDR_IRQ_STAT, 32'h0);
      repeat (24) begin
         d = $random(seed);
         e = $random(seed);
         nd = d[16];
         mmsk = d[19:17];
         xfer(csf_pkg::ADDR_CTRL, 1'b1, {31'h0, nd});
         xfer(csf_pkg::ADDR_IRQ_MASK, 1'b1, {29'h0, mmsk});
         wr_flags(d[15:0]);
         rd_chk("flags write", csf_pkg::ADDR_FLAGS, img());
         rd_chk("mask", csf_pkg::ADDR_IRQ_MASK, {29'h0, mmsk});
         check("prio", {29'h0, cpu_priority_level_o}, {29'h0, mf[7:5]});
         check("nesting", {31'h0, nesting_disable_o}, {31'h0, nd});
         wr_flags(16'h0);
         acc_upd_i <= 1'b1;
         {acc_a_ovf_i, acc_b_ovf_i, acc_a_sat_i, acc_b_sat_i} <= e[3:0];
         {alu_valid_i, alu_sub_i, alu_byte_i} <= {1'b1, e[4], e[5]};
         alu_a_i <= e[31:16];
         alu_b_i <= e[15:0];
         @(posedge ref_clk_i);
         // second result leaves saturation, flags must stay
         {acc_a_sat_i, acc_b_sat_i, alu_valid_i} <= 3'h0;
         @(posedge ref_clk_i);
         acc_upd_i <= 1'b0;
         mf[15:12] = e[3:0];
         mf[8] = nib(e[31:16], e[15:0], e[4], e[5]);
         mst = {e[3] | e[2], e[0], e[1]};
         repeat (2) @(posedge ref_clk_i);
         check("irq", {31'h0, irq_o}, {31'h0, |(mst & mmsk)});
         rd_chk("flags acc", csf_pkg::ADDR_FLAGS, img());
         check("image", {16'h0, cpu_flags_register_o}, img());
         rd_chk("stat", csf_pkg::ADDR_IRQ_STAT, {29'h0, mst});
         rd_chk("stat clear", csf_pkg::ADDR_IRQ_STAT, 32'h0);
         check("irq clear", {31'h0, irq_o}, 32'h0);
      end
      reset_chk();
      print_verdict();
   end

   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule : csf_flags_tb
